// *** dwl_write_leveling.sv ***
// Contract
// - Strobe rise samples clock, prime bit reports
// - Narrow parts: feedback on bit 0, others low
// - Wide part: bits 0 and 8, others low
// - Mode bit 7 enables leveling
// - Mode bit 12 gates outputs and strobe
// - Strobe receives, data bits drive
// - ODT terminates strobe only, data never
// - Outputs off: any nominal value allowed
// - Outputs on: only 40, 60, 120
// - Data pins go undefined-driven on entry (code drives them low until feedback)
// - Feedback driven soon after each rise
`timescale 1ns/1ns
`default_nettype none
module dwl_write_leveling
  import dwl_pkg::*;
(
  input  wire logic                         clk_sys_in,
  input  wire logic                         rst_b_in,
  input  wire logic                         ldqs_clk_in,
  input  wire logic                         udqs_clk_in,
  input  wire logic                         ck_level_in,
  input  wire logic                         wide_org_in,
  input  wire logic                         mode_wr_in,
  input  wire dwl_pkg::dwl_mode_s           mode_in,
  input  wire logic                         dll_locked_in,
  input  wire logic                         odt_in,
  input  wire logic                         cmd_valid_in,
  input  wire logic                         cmd_nop_in,
  output logic [dwl_pkg::DWL_DQ_W-1:0]      dq_out,
  output logic [dwl_pkg::DWL_DQ_W-1:0]      dq_oe_out,
  output logic                              dqs_rx_en_out,
  output logic                              dqs_term_en_out,
  output logic                              dq_term_en_out,
  output logic                              rtt_illegal_out,
  output logic                              wl_active_out,
  output logic                              entry_err_out,
  output logic                              cmd_err_out
);

  dwl_mode_s                mode_q;
  dwl_mode_s                mode_d;
  dwl_state_e               state_q;
  dwl_state_e               state_d;
  logic [DWL_MOD_W-1:0]     cnt_q;
  logic [DWL_MOD_W-1:0]     cnt_d;
  logic                     capture_q;
  logic                     capture_d;
  logic                     lo_raw;
  logic                     hi_raw;
  logic                     lo_meta_q;
  logic                     lo_sync_q;
  logic                     hi_meta_q;
  logic                     hi_sync_q;
  logic [DWL_DQ_W-1:0]      dq_q;
  logic [DWL_DQ_W-1:0]      dq_d;
  logic [DWL_DQ_W-1:0]      oe_q;
  logic [DWL_DQ_W-1:0]      oe_d;
  logic                     rx_q;
  logic                     rx_d;
  logic                     dqs_term_q;
  logic                     dqs_term_d;
  logic                     dq_term_q;
  logic                     dq_term_d;
  logic                     illegal_q;
  logic                     illegal_d;
  logic                     entry_err_q;
  logic                     entry_err_d;
  logic                     cmd_err_q;
  logic                     cmd_err_d;
  logic                     odt_live;

  // Mode register and leveling state
  always_comb begin
    mode_d      = mode_q;
    state_d     = state_q;
    cnt_d       = cnt_q;
    entry_err_d = entry_err_q;
    cmd_err_d   = cmd_err_q;
    if (mode_wr_in) begin
      mode_d = mode_in;
      cnt_d  = DWL_MOD_W'(DWL_MOD_CYCLES);
      if (mode_in.wl_en) begin
        state_d = DWL_ST_SETTLE;
      end else begin
        state_d = DWL_ST_NORMAL;
      end
      if (mode_in.wl_en && !mode_q.wl_en && !dll_locked_in) begin
        entry_err_d = 1'b1;
      end
      if (!mode_in.wl_en) begin
        cmd_err_d = 1'b0;
      end
    end else if (state_q == DWL_ST_SETTLE) begin
      if (cnt_q <= DWL_MOD_W'(1)) begin
        state_d = DWL_ST_LEVEL;
        cnt_d   = DWL_CNT_RST;
      end else begin
        cnt_d = cnt_q - DWL_MOD_W'(1);
      end
    end
    if (mode_q.wl_en && cmd_valid_in && !cmd_nop_in) begin
      cmd_err_d = 1'b1;
    end
    if (mode_in.wl_en && mode_wr_in) begin
      entry_err_d = entry_err_d;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_q      <= DWL_MODE_RST;
      state_q     <= DWL_ST_NORMAL;
      cnt_q       <= DWL_CNT_RST;
      entry_err_q <= 1'b0;
      cmd_err_q   <= 1'b0;
    end else begin
      mode_q      <= mode_d;
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      entry_err_q <= entry_err_d;
      cmd_err_q   <= cmd_err_d;
    end
  end

  // Strobe-domain samplers, one per byte lane
  dwl_lane_sampler u_low_lane (
    .strobe_clk_in (ldqs_clk_in),
    .rst_b_in      (rst_b_in),
    .capture_en_in (capture_q),
    .ck_level_in   (ck_level_in),
    .sample_out    (lo_raw)
  );

  dwl_lane_sampler u_high_lane (
    .strobe_clk_in (udqs_clk_in),
    .rst_b_in      (rst_b_in),
    .capture_en_in (capture_q),
    .ck_level_in   (ck_level_in),
    .sample_out    (hi_raw)
  );

  // Sample crossings into the clock domain
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lo_meta_q <= 1'b0;
      lo_sync_q <= 1'b0;
      hi_meta_q <= 1'b0;
      hi_sync_q <= 1'b0;
    end else begin
      lo_meta_q <= lo_raw;
      lo_sync_q <= lo_meta_q;
      hi_meta_q <= hi_raw;
      hi_sync_q <= hi_meta_q;
    end
  end

  // Pin buffers and termination
  always_comb begin
    odt_live   = odt_in && (state_q == DWL_ST_LEVEL);
    capture_d  = mode_q.wl_en && !mode_q.qoff;
    dq_d       = DWL_DQ_RST;
    oe_d       = DWL_DQ_RST;
    rx_d       = 1'b0;
    dqs_term_d = 1'b0;
    dq_term_d  = 1'b0;
    illegal_d  = 1'b0;
    if (mode_q.wl_en) begin
      if (!mode_q.qoff) begin
        rx_d = 1'b1;
        oe_d = wide_org_in ? DWL_OE_X16 : DWL_OE_X8;
        dq_d[DWL_LOW_DQ] = lo_sync_q;
        if (wide_org_in) begin
          dq_d[DWL_HIGH_DQ] = hi_sync_q;
        end
        dqs_term_d = odt_live && dwl_rtt_rx_ok(mode_q.rtt);
        illegal_d  = odt_live && !dwl_rtt_rx_ok(mode_q.rtt);
      end else begin
        dqs_term_d = odt_live && dwl_rtt_any(mode_q.rtt);
      end
      dq_term_d = 1'b0;
    end else begin
      dqs_term_d = odt_in && dwl_rtt_any(mode_q.rtt);
      dq_term_d  = odt_in && dwl_rtt_any(mode_q.rtt);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      capture_q  <= 1'b0;
      dq_q       <= DWL_DQ_RST;
      oe_q       <= DWL_DQ_RST;
      rx_q       <= 1'b0;
      dqs_term_q <= 1'b0;
      dq_term_q  <= 1'b0;
      illegal_q  <= 1'b0;
    end else begin
      capture_q  <= capture_d;
      dq_q       <= dq_d;
      oe_q       <= oe_d;
      rx_q       <= rx_d;
      dqs_term_q <= dqs_term_d;
      dq_term_q  <= dq_term_d;
      illegal_q  <= illegal_d;
    end
  end

  assign dq_out          = dq_q;
  assign dq_oe_out       = oe_q;
  assign dqs_rx_en_out   = rx_q;
  assign dqs_term_en_out = dqs_term_q;
  assign dq_term_en_out  = dq_term_q;
  assign rtt_illegal_out = illegal_q;
  assign wl_active_out   = mode_q.wl_en;
  assign entry_err_out   = entry_err_q;
  assign cmd_err_out     = cmd_err_q;

endmodule : dwl_write_leveling
`default_nettype wire

// *** dwl_pkg.sv ***
package dwl_pkg;

  // Mode register one, write leveling related fields
  localparam int unsigned DWL_MR1_WL_BIT   = 7;
  localparam int unsigned DWL_MR1_QOFF_BIT = 12;

  // Nominal termination codes, bits {9,6,2} packed low to high
  localparam logic [2:0] DWL_RTT_OFF = 3'h0;
  localparam logic [2:0] DWL_RTT_60  = 3'h1;
  localparam logic [2:0] DWL_RTT_120 = 3'h2;
  localparam logic [2:0] DWL_RTT_40  = 3'h3;
  localparam logic [2:0] DWL_RTT_20  = 3'h4;
  localparam logic [2:0] DWL_RTT_30  = 3'h5;

  // Mode-set delay before the device acts on the ODT pin
  localparam int unsigned DWL_MOD_NS     = 48;
  localparam int unsigned DWL_CK_PERIOD  = 4;
  localparam int unsigned DWL_MOD_CYCLES =
    (DWL_MOD_NS + DWL_CK_PERIOD - 1) / DWL_CK_PERIOD;
  localparam int unsigned DWL_MOD_W      = 5;

  // Bus widths and prime bit positions
  localparam int unsigned DWL_DQ_W    = 16;
  localparam int unsigned DWL_LOW_DQ  = 0;
  localparam int unsigned DWL_HIGH_DQ = 8;

  // Reset values and output-enable patterns
  localparam logic [DWL_DQ_W-1:0] DWL_DQ_RST  = 16'h0000;
  localparam logic [DWL_DQ_W-1:0] DWL_OE_X8   = 16'h00FF;
  localparam logic [DWL_DQ_W-1:0] DWL_OE_X16  = 16'hFFFF;
  localparam logic [DWL_MOD_W-1:0] DWL_CNT_RST = 5'h00;

  typedef struct packed {
    logic       qoff;
    logic       wl_en;
    logic [2:0] rtt;
  } dwl_mode_s;

  localparam dwl_mode_s DWL_MODE_RST = '{qoff: 1'b0, wl_en: 1'b0,
                                         rtt: 3'h0};

  typedef enum logic [1:0] {
    DWL_ST_NORMAL,
    DWL_ST_SETTLE,
    DWL_ST_LEVEL
  } dwl_state_e;

  // Terminations allowed while the strobe is received
  function automatic logic dwl_rtt_rx_ok(input logic [2:0] code);
    dwl_rtt_rx_ok = (code == DWL_RTT_40) || (code == DWL_RTT_60) ||
                    (code == DWL_RTT_120);
  endfunction : dwl_rtt_rx_ok

  // Any nominal termination value
  function automatic logic dwl_rtt_any(input logic [2:0] code);
    dwl_rtt_any = dwl_rtt_rx_ok(code) || (code == DWL_RTT_20) ||
                  (code == DWL_RTT_30);
  endfunction : dwl_rtt_any

endpackage : dwl_pkg

// *** dwl_lane_sampler.sv ***
`timescale 1ns/1ns
`default_nettype none
module dwl_lane_sampler
  import dwl_pkg::*;
(
  input  wire logic strobe_clk_in,
  input  wire logic rst_b_in,
  input  wire logic capture_en_in,
  input  wire logic ck_level_in,
  output logic      sample_out
);

  logic en_meta_q;
  logic en_sync_q;
  logic sample_q;
  logic en_meta_d;
  logic en_sync_d;
  logic sample_d;

  // Enable crossing and capture of the clock level on each strobe rise
  always_comb begin
    en_meta_d = capture_en_in;
    en_sync_d = en_meta_q;
    sample_d  = en_sync_q ? ck_level_in : 1'b0;
  end

  always_ff @(posedge strobe_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      en_meta_q <= 1'b0;
      en_sync_q <= 1'b0;
      sample_q  <= 1'b0;
    end else begin
      en_meta_q <= en_meta_d;
      en_sync_q <= en_sync_d;
      sample_q  <= sample_d;
    end
  end

  assign sample_out = sample_q;

endmodule : dwl_lane_sampler
`default_nettype wire

// *** dwl_write_leveling_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module dwl_write_leveling_sva
  import dwl_pkg::*;
(
  input wire logic               clk_sys_in,
  input wire logic               rst_b_in,
  input wire logic               wide_org_in,
  input wire logic               mode_wr_in,
  input wire dwl_pkg::dwl_mode_s mode_in,
  input wire logic               dll_locked_in,
  input wire logic               odt_in,
  input wire logic               cmd_valid_in,
  input wire logic               cmd_nop_in,
  input wire logic [15:0]        dq_out,
  input wire logic [15:0]        dq_oe_out,
  input wire logic               dqs_rx_en_out,
  input wire logic               dqs_term_en_out,
  input wire logic               dq_term_en_out,
  input wire logic               rtt_illegal_out,
  input wire logic               wl_active_out,
  input wire logic               entry_err_out,
  input wire logic               cmd_err_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_mr_write;
    mode_wr_in ##1 !mode_wr_in;
  endsequence
  sequence s_entry;
    mode_wr_in && mode_in.wl_en && !wl_active_out;
  endsequence
  a_mode_active: assert property (
    mode_wr_in |=> wl_active_out == $past(mode_in.wl_en))
    else $error("leveling flag wrong");
  a_rx_follows: assert property (
    s_mr_write |=> dqs_rx_en_out == $past(mode_in.wl_en & !mode_in.qoff, 2))
    else $error("strobe receiver wrong");
  a_oe_pattern: assert property (
    dqs_rx_en_out |-> dq_oe_out == (wide_org_in ? 16'hFFFF : 16'h00FF))
    else $error("output enables wrong");
  a_dq_quiet: assert property (
    (dq_out & 16'hFEFE) == 16'h0000)
    else $error("non prime bit high");
  a_upper_quiet: assert property (
    !wide_org_in |-> !dq_out[8])
    else $error("upper prime used in narrow part");
  a_dq_no_term: assert property (
    wl_active_out && $past(wl_active_out) |-> !dq_term_en_out)
    else $error("data terminated in leveling");
  a_term_cause: assert property (
    dqs_term_en_out |-> $past(odt_in))
    else $error("termination without odt");
  a_rtt_block: assert property (
    rtt_illegal_out |-> !dqs_term_en_out)
    else $error("illegal termination applied");
  a_settle_hold: assert property (
    s_entry |-> ##2 (!dqs_term_en_out) [*8])
    else $error("odt honoured before mode delay");
  a_cmd_flag: assert property (
    cmd_valid_in && !cmd_nop_in && wl_active_out |=> cmd_err_out)
    else $error("illegal command not flagged");
  a_entry_flag: assert property (
    (s_entry and !dll_locked_in) |=> entry_err_out)
    else $error("unlocked entry not flagged");
endmodule : dwl_write_leveling_sva
bind dwl_write_leveling dwl_write_leveling_sva u_sva (.*);
`default_nettype wire

// *** dwl_ctrl_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module dwl_ctrl_model (
  output logic ldqs_out,
  output logic udqs_out
);
  // Strobes parked low between toggles
  initial begin
    ldqs_out = 1'b0;
    udqs_out = 1'b0;
  end
  // One toggle, 40 ns high and low, upper lane 20 ns later
  task automatic pulse(input int skew_ns);
    #(skew_ns);
    ldqs_out = 1'b1;
    #20 udqs_out = 1'b1;
    #20 ldqs_out = 1'b0;
    #20 udqs_out = 1'b0;
    #20;
  endtask : pulse
endmodule : dwl_ctrl_model
`default_nettype wire

// *** dwl_write_leveling_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module dwl_write_leveling_tb;
  import dwl_pkg::*;
  logic        clk_sys_in = 1'b0, rst_b_in = 1'b0, ck = 1'b0, wide = 1'b0;
  logic        mwr = 1'b0, dll = 1'b0, odt = 1'b0, cv = 1'b0, cn = 1'b0;
  dwl_mode_s   mode = '0;
  logic [15:0] dq, oe, lf = 16'h5108;
  logic        rx, term, dqt, ill, act, eerr, cerr, ldqs, udqs;
  int          error_cnt = 0, samples_checked = 0, thr, found;
  always #2 clk_sys_in = ~clk_sys_in;
  dwl_write_leveling u_dwl_write_leveling (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .ldqs_clk_in(ldqs),
    .udqs_clk_in(udqs), .ck_level_in(ck), .wide_org_in(wide),
    .mode_wr_in(mwr), .mode_in(mode), .dll_locked_in(dll), .odt_in(odt),
    .cmd_valid_in(cv), .cmd_nop_in(cn), .dq_out(dq), .dq_oe_out(oe),
    .dqs_rx_en_out(rx), .dqs_term_en_out(term), .dq_term_en_out(dqt),
    .rtt_illegal_out(ill), .wl_active_out(act), .entry_err_out(eerr),
    .cmd_err_out(cerr));
  dwl_ctrl_model u_ctrl (.ldqs_out(ldqs), .udqs_out(udqs));
  function automatic logic [15:0] nxt(input logic [15:0] x);
    nxt = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nxt
  function automatic logic [15:0] oe_exp(input logic w, input logic q);
    oe_exp = q ? 16'h0000 : (w ? 16'hFFFF : 16'h00FF);
  endfunction : oe_exp
  function automatic logic term_exp(input logic q, input logic [2:0] r);
    term_exp = (r != 3'h0) && (q || (r inside {3'h1, 3'h2, 3'h3}));
  endfunction : term_exp
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (!ok) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : w
  task automatic mr(input logic e, input logic q, input logic [2:0] r);
    @(posedge clk_sys_in);
    mode <= '{qoff: q, wl_en: e, rtt: r};
    mwr  <= 1'b1;
    @(posedge clk_sys_in);
    mwr  <= 1'b0;
  endtask : mr
  task automatic cmd(input logic nop);
    @(posedge clk_sys_in);
    cv <= 1'b1;
    cn <= nop;
    @(posedge clk_sys_in);
    cv <= 1'b0;
  endtask : cmd
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    #300000;
    error_cnt++;
    conclude();
  end
  initial begin
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_sys_in);
      rst_b_in <= 1'b0;
      wide     <= p[0];
      dll      <= p[0];
      odt      <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      w(1);
      chk(act === 1'b0 && oe === 16'h0000, "reset");
      mr(1'b1, 1'b0, 3'h3);
      w(2);
      chk(act === 1'b1 && eerr === !p[0], "entry");
      chk(oe === oe_exp(wide, 1'b0) && dq === 16'h0000, "oe");
      @(posedge clk_sys_in);
      odt <= 1'b1;
      w(4);
      chk(term === 1'b0, "settle");
      w(12);
      chk(term === 1'b1 && dqt === 1'b0, "term");
      cmd(1'b1);
      w(1);
      chk(cerr === 1'b0, "nop");
      cmd(1'b0);
      w(1);
      chk(cerr === 1'b1, "cmd");
      for (int k = 0; k < 12; k++) begin
        mr(1'b1, k[0], 3'(k / 2));
        w(16);
        chk(term === term_exp(k[0], 3'(k / 2)), "rtt");
        chk(rx === !k[0] && oe === oe_exp(wide, k[0]), "gate");
        if (k / 2 != 0)
          chk(ill === (!k[0] && k / 2 >= 4), "illegal");
      end
      mr(1'b1, 1'b0, 3'h3);
      w(14);
      thr = 2 + lf % 13;
      lf  = nxt(lf);
      found = -1;
      for (int s = 0; s < 16; s++) begin
        @(posedge clk_sys_in);
        ck <= (s >= thr);
        u_ctrl.pulse(s);
        w(8);
        chk(dq === {7'h00, wide & ck, 7'h00, ck}, "feedback");
        if (found < 0 && dq[0] === 1'b1)
          found = s;
      end
      chk(found == thr, "sweep");
      @(posedge clk_sys_in);
      odt <= 1'b0;
      mr(1'b0, 1'b0, 3'h1);
      w(3);
      chk(act === 1'b0 && oe === 16'h0000 && cerr === 1'b0, "exit");
      @(posedge clk_sys_in);
      odt <= 1'b1;
      w(2);
      chk(dqt === 1'b1 && term === 1'b1, "normal odt");
      cmd(1'b0);
      w(1);
      chk(cerr === 1'b0, "normal cmd");
      $display("pass %0d done, wide %0d", p, wide);
    end
    conclude();
  end
endmodule : dwl_write_leveling_tb
`default_nettype wire
